// ===== rtl/pft_table_access.sv
// table access path between the core's working registers and the 24-bit program flash
// assumes every input comes from core logic on clk; requests are held until req_ready
// Contract
// (R01) low read returns word bits 15:0
// (R02) low write targets word bits 15:0
// (R03) high read/write use word bits 23:16
// (R04) word or byte mode per operation
// (R05) phantom upper byte reads as zero
// (R06) phantom byte write changes nothing
// (R07) low and high halves share one address
// (R08) address is page low byte over EA
// (R09) upper 23 EA bits select the word
// (R10) byte mode LSb picks high/low byte
// (R11) word mode ignores EA LSb
// (R12) byte write uses source bits 7:0
// (R13) working register is data source/destination
// (R14) requester loads page and address first
// (R15) byte post-increment advances EA by one
// (R16) writes fill latches, start programs array
// (R17) 128 latches hold one row
// (R18) page register persists until rewritten
`timescale 1ns/1ps
`default_nettype none

module pft_table_access
  import pft_pkg::*;
#(
  parameter int PM_WORDS = PFT_PM_WORDS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pft_req_s req,
  output logic req_ready,
  output pft_resp_s resp,
  input wire logic page_we,
  input wire logic [PFT_PAGE_W-1:0] page_wdata,
  output logic [PFT_PAGE_W-1:0] table_page_reg,
  input wire logic wreg_we,
  input wire logic [PFT_WREG_IDX_W-1:0] wreg_widx,
  input wire logic [PFT_DATA_W-1:0] wreg_wdata,
  input wire logic [PFT_WREG_IDX_W-1:0] wreg_ridx,
  output logic [PFT_DATA_W-1:0] wreg_rdata,
  input wire logic prog_start,
  output logic prog_busy,
  output logic prog_done
);

  localparam int PM_IDX_W = $clog2(PM_WORDS);
  localparam int ROW_W = PM_IDX_W - PFT_LATCH_IDX_W;

  // ==========================================================================
  // data path functions
  function automatic logic [PFT_DATA_W-1:0] read_sel(
    input pft_op_e op,
    input logic byte_mode,
    input logic lsb,
    input logic [PFT_WORD_W-1:0] w
  );
    logic [PFT_DATA_W-1:0] half;
    half = w[PFT_LOW_HI:PFT_LOW_LO];                                    // [R01]
    if (op == PFT_TABLE_READ_HIGH_OP) begin
      half = {PFT_PHANTOM_BYTE, w[PFT_HIGH_HI:PFT_HIGH_LO]};           // [R03] [R05]
    end
    if (!byte_mode) begin                                              // [R04]
      read_sel = half;                                                 // [R11]
    end else if (lsb) begin
      read_sel = {PFT_PHANTOM_BYTE, half[PFT_LOW_HI:PFT_BYTE_HI_LO]};  // [R10] [R05]
    end else begin
      read_sel = {PFT_PHANTOM_BYTE, half[PFT_BYTE_HI_LO-1:PFT_LOW_LO]}; // [R10]
    end
  endfunction

  function automatic logic [PFT_WORD_W-1:0] write_merge(
    input pft_op_e op,
    input logic byte_mode,
    input logic lsb,
    input logic [PFT_WORD_W-1:0] old,
    input logic [PFT_DATA_W-1:0] src
  );
    logic [PFT_BYTE_W-1:0] lo_byte;
    lo_byte = src[PFT_BYTE_W-1:0];                                     // [R12]
    write_merge = old;
    if (op == PFT_TABLE_WRITE_LOW_OP) begin
      if (!byte_mode) begin
        write_merge = {old[PFT_HIGH_HI:PFT_HIGH_LO], src};             // [R02] [R11]
      end else if (lsb) begin
        write_merge = {old[PFT_HIGH_HI:PFT_HIGH_LO], lo_byte, old[PFT_BYTE_HI_LO-1:0]}; // [R10]
      end else begin
        write_merge = {old[PFT_HIGH_HI:PFT_BYTE_HI_LO], lo_byte};      // [R10]
      end
    end else if (op == PFT_TABLE_WRITE_HIGH_OP) begin
      // the upper source byte lands on the phantom byte and is dropped
      if (!byte_mode || !lsb) begin
        write_merge = {lo_byte, old[PFT_LOW_HI:PFT_LOW_LO]};           // [R03] [R06]
      end else begin
        write_merge = old;                                             // [R06]
      end
    end
  endfunction

  function automatic logic [PFT_DATA_W-1:0] ea_advance(
    input logic [PFT_DATA_W-1:0] ea,
    input logic byte_mode
  );
    ea_advance = ea + (byte_mode ? PFT_BYTE_STEP : PFT_WORD_STEP);      // [R15]
  endfunction

  function automatic logic wreg_hit(
    input logic [PFT_WREG_IDX_W-1:0] idx,
    input int n
  );
    wreg_hit = (idx == PFT_WREG_IDX_W'(n));
  endfunction

  // ==========================================================================
  // storage
  logic [PFT_WORD_W-1:0] pm_mem [PM_WORDS];
  logic [PFT_WORD_W-1:0] latch_mem [PFT_LATCH_COUNT];
  logic [PFT_DATA_W-1:0] wreg_q [PFT_NUM_WREG];

  // ==========================================================================
  // control state
  pft_state_e state_q, state_d;
  logic [PFT_LATCH_IDX_W-1:0] cnt_q, cnt_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic [PFT_PAGE_W-1:0] page_q, page_d;
  pft_resp_s resp_q, resp_d;
  logic prog_done_q, prog_done_d;
  logic [PFT_DATA_W-1:0] wreg_rdata_q, wreg_rdata_d;

  // ==========================================================================
  // request decode
  logic take;
  logic is_write;
  logic [PFT_DATA_W-1:0] ea;
  logic [PFT_DATA_W-1:0] src;
  logic [PFT_ADDR_W-1:0] full_addr;
  logic [PFT_ADDR_W-2:0] word_addr;
  logic [PM_IDX_W-1:0] pm_idx;
  logic [PFT_LATCH_IDX_W-1:0] latch_idx;
  logic [PFT_WORD_W-1:0] latch_new;
  logic [PFT_DATA_W-1:0] rd_val;
  logic [PFT_DATA_W-1:0] ea_next;
  logic [PM_IDX_W-1:0] prog_idx;

  assign req_ready = (state_q == PFT_ST_IDLE);

  always_comb begin
    take = req_valid && req_ready;
    is_write = req.op[1];
    ea = wreg_q[req.addr_wreg];
    src = wreg_q[req.data_wreg];                                       // [R13]
    full_addr = {page_q, ea};                                          // [R08]
    word_addr = full_addr[PFT_ADDR_W-1:PFT_EA_SEL_LO];                 // [R09]
    // both halves come from the same word entry
    // an array smaller than the address space aliases: upper index bits are not decoded
    pm_idx = word_addr[PM_IDX_W-1:0];                                  // [R07]
    latch_idx = word_addr[PFT_LATCH_IDX_W-1:0];                        // [R17]
    latch_new = write_merge(req.op, req.byte_mode, ea[0], latch_mem[latch_idx], src);
    rd_val = read_sel(req.op, req.byte_mode, ea[0], pm_mem[pm_idx]);
    ea_next = req.post_inc ? ea_advance(ea, req.byte_mode) : ea;
    prog_idx = {row_q, cnt_q};
  end

  // ==========================================================================
  // controller next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    row_d = row_q;
    prog_done_d = 1'b0;
    resp_d = resp_q;
    resp_d.done = 1'b0;
    if (take) begin
      resp_d.done = 1'b1;
      resp_d.next_ea = ea_next;
      if (!is_write) begin
        resp_d.rdata = rd_val;
      end else begin
        // the row to program follows the most recent table write
        row_d = word_addr[PM_IDX_W-1:PFT_LATCH_IDX_W];                 // [R16]
      end
    end
    case (state_q)
      PFT_ST_IDLE: begin
        // a start beside a taken request is dropped so the row cannot move under the copy
        if (prog_start && !take) begin
          state_d = PFT_ST_PROG;                                       // [R16]
          cnt_d = PFT_CNT_RST;
        end
      end
      PFT_ST_PROG: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == PFT_CNT_LAST) begin
          state_d = PFT_ST_IDLE;
          prog_done_d = 1'b1;
        end
      end
      default: begin
        state_d = PFT_ST_IDLE;
        cnt_d = PFT_CNT_RST;
      end
    endcase
  end

  // page register only changes on an explicit write
  always_comb begin
    page_d = page_q;
    if (page_we) begin
      page_d = page_wdata;                                             // [R18]
    end
  end

  // read port shows the register as of the previous edge, one cycle late
  always_comb begin
    wreg_rdata_d = wreg_q[wreg_ridx];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PFT_ST_IDLE;
      cnt_q <= PFT_CNT_RST;
      row_q <= '0;
      page_q <= PFT_PAGE_RST;
      resp_q <= '0;
      prog_done_q <= 1'b0;
      wreg_rdata_q <= PFT_WREG_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      row_q <= row_d;
      page_q <= page_d;
      resp_q <= resp_d;
      prog_done_q <= prog_done_d;
      wreg_rdata_q <= wreg_rdata_d;
    end
  end

  // ==========================================================================
  // working registers: read write-back beats post-increment beats the core port
  logic wb_en;
  logic inc_en;
  logic [PFT_DATA_W-1:0] wreg_d [PFT_NUM_WREG];

  always_comb begin
    wb_en = take && !is_write;                                         // [R13]
    inc_en = take && req.post_inc;                                     // [R15]
    for (int i = 0; i < PFT_NUM_WREG; i++) begin
      wreg_d[i] = wreg_q[i];
      if (wb_en && wreg_hit(req.data_wreg, i)) begin
        // byte reads arrive zero-extended, so the whole register is replaced
        wreg_d[i] = rd_val;                                            // [R13]
      end else if (inc_en && wreg_hit(req.addr_wreg, i)) begin
        wreg_d[i] = ea_next;                                           // [R15]
      end else if (wreg_we && wreg_hit(wreg_widx, i)) begin
        wreg_d[i] = wreg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PFT_NUM_WREG; i++) begin
        wreg_q[i] <= PFT_WREG_RST;
      end
    end else begin
      for (int i = 0; i < PFT_NUM_WREG; i++) begin
        wreg_q[i] <= wreg_d[i];
      end
    end
  end

  // ==========================================================================
  // holding latches and array; data storage, so no reset
  logic latch_we;
  logic pm_we;
  logic [PFT_WORD_W-1:0] pm_wdata;

  always_comb begin
    // the array only takes whole rows out of the latches, never core data directly
    latch_we = take && is_write;                                       // [R16]
    pm_we = (state_q == PFT_ST_PROG);                                  // [R16]
    pm_wdata = latch_mem[cnt_q];                                       // [R17]
  end

  always_ff @(posedge clk) begin
    if (latch_we) begin
      latch_mem[latch_idx] <= latch_new;                               // [R06]
    end
    if (pm_we) begin
      pm_mem[prog_idx] <= pm_wdata;                                    // [R17]
    end
  end

  // ==========================================================================
  // outputs
  assign resp = resp_q;
  assign table_page_reg = page_q;
  assign wreg_rdata = wreg_rdata_q;
  assign prog_busy = (state_q == PFT_ST_PROG);
  assign prog_done = prog_done_q;

endmodule

`default_nettype wire

// ===== rtl/pft_pkg.sv
// constants, encodings and carrier structs for the program flash table access block
// assumes a single core clock domain; all users import the whole package
package pft_pkg;

  // ==========================================================================
  // widths
  localparam int PFT_DATA_W = 16;
  localparam int PFT_PAGE_W = 8;
  localparam int PFT_ADDR_W = 24;
  localparam int PFT_WORD_W = 24;
  localparam int PFT_BYTE_W = 8;
  localparam int PFT_WREG_IDX_W = 4;
  localparam int PFT_NUM_WREG = 16;
  localparam int PFT_LATCH_COUNT = 128;
  localparam int PFT_LATCH_IDX_W = 7;
  localparam int PFT_PM_WORDS = 4096;

  // ==========================================================================
  // field positions inside one program word and its access address
  localparam int PFT_LOW_HI = 15;
  localparam int PFT_LOW_LO = 0;
  localparam int PFT_HIGH_HI = 23;
  localparam int PFT_HIGH_LO = 16;
  localparam int PFT_BYTE_HI_LO = 8;
  localparam int PFT_EA_SEL_LO = 1;

  // ==========================================================================
  // values after reset and fixed values
  localparam logic [PFT_PAGE_W-1:0] PFT_PAGE_RST = 8'h00;
  localparam logic [PFT_DATA_W-1:0] PFT_WREG_RST = 16'h0000;
  localparam logic [PFT_BYTE_W-1:0] PFT_PHANTOM_BYTE = 8'h00;
  localparam logic [PFT_DATA_W-1:0] PFT_BYTE_STEP = 16'h0001;
  localparam logic [PFT_DATA_W-1:0] PFT_WORD_STEP = 16'h0002;
  localparam logic [PFT_LATCH_IDX_W-1:0] PFT_CNT_RST = 7'h00;
  localparam logic [PFT_LATCH_IDX_W-1:0] PFT_CNT_LAST = 7'h7F;

  // ==========================================================================
  // table operations and controller states
  typedef enum logic [1:0] {
    PFT_TABLE_READ_LOW_OP = 2'h0,
    PFT_TABLE_READ_HIGH_OP = 2'h1,
    PFT_TABLE_WRITE_LOW_OP = 2'h2,
    PFT_TABLE_WRITE_HIGH_OP = 2'h3
  } pft_op_e;

  typedef enum logic [1:0] {
    PFT_ST_IDLE = 2'b01,
    PFT_ST_PROG = 2'b10
  } pft_state_e;

  // ==========================================================================
  // carriers
  typedef struct packed {
    pft_op_e op;
    logic byte_mode;
    logic post_inc;
    logic [PFT_WREG_IDX_W-1:0] addr_wreg;
    logic [PFT_WREG_IDX_W-1:0] data_wreg;
  } pft_req_s;

  typedef struct packed {
    logic done;
    logic [PFT_DATA_W-1:0] rdata;
    logic [PFT_DATA_W-1:0] next_ea;
  } pft_resp_s;

endpackage

// ===== verification/pft_table_access_chk.sv
// checker for the table access block, bound from the bench top
// assumes one core clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pft_table_access_chk
  import pft_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pft_req_s req,
  input wire logic req_ready,
  input wire pft_resp_s resp,
  input wire logic page_we,
  input wire logic [PFT_PAGE_W-1:0] page_wdata,
  input wire logic [PFT_PAGE_W-1:0] table_page_reg,
  input wire logic wreg_we,
  input wire logic [PFT_WREG_IDX_W-1:0] wreg_widx,
  input wire logic [PFT_DATA_W-1:0] wreg_wdata,
  input wire logic [PFT_WREG_IDX_W-1:0] wreg_ridx,
  input wire logic [PFT_DATA_W-1:0] wreg_rdata,
  input wire logic prog_start,
  input wire logic prog_busy,
  input wire logic prog_done
);
  // ==========================================================================
  // busy run length, too long for a repetition count
  logic [7:0] busy_cnt_q;
  logic [7:0] busy_cnt_d;
  logic take;
  assign take = req_valid && req_ready;
  always_comb begin
    busy_cnt_d = prog_busy ? busy_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 8'h00;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_done_after_take: assert property (take |=> resp.done)
    else $error("no done after a taken request");
  a_done_has_cause: assert property (resp.done |-> $past(take))
    else $error("done without a taken request");
  a_read_hold: assert property (!(take && !req.op[1]) |=> $stable(resp.rdata))
    else $error("read data moved without a read");
  a_upper_zero: assert property (take && !req.op[1] && (req.byte_mode || req.op == PFT_TABLE_READ_HIGH_OP)
    |=> resp.rdata[15:8] == 8'h00) else $error("upper read byte not zero");
  a_page_load: assert property (page_we |=> table_page_reg == $past(page_wdata))
    else $error("page register not loaded");
  a_page_keep: assert property (!page_we |=> $stable(table_page_reg))
    else $error("page register changed unasked");
  a_busy_start: assert property ($rose(prog_busy) |-> $past(prog_start))
    else $error("programming began without start");
  a_busy_blocks: assert property (prog_busy |-> !req_ready)
    else $error("request accepted during row copy");
  a_row_len: assert property ($fell(prog_busy) |-> busy_cnt_q == 8'h80 && prog_done)
    else $error("row copy length wrong");
  a_wreg_path: assert property (wreg_we && !req_valid ##1 (wreg_ridx == $past(wreg_widx) && !req_valid)
    |=> wreg_rdata == $past(wreg_wdata, 2)) else $error("working register lost its value");
endmodule
`default_nettype wire

// ===== verification/pft_core_model.sv
// core-side model: loads page and working registers, issues table requests
// assumes it drives every input of the block except clk and rst_n on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module pft_core_model
  import pft_pkg::*;
(
  input wire logic clk,
  input wire logic req_ready,
  input wire pft_resp_s resp,
  input wire logic [PFT_DATA_W-1:0] wreg_rdata,
  input wire logic prog_done,
  output logic req_valid,
  output pft_req_s req,
  output logic page_we,
  output logic [PFT_PAGE_W-1:0] page_wdata,
  output logic wreg_we,
  output logic [PFT_WREG_IDX_W-1:0] wreg_widx,
  output logic [PFT_DATA_W-1:0] wreg_wdata,
  output logic [PFT_WREG_IDX_W-1:0] wreg_ridx,
  output logic prog_start
);
  // ==========================================================================
  // released data is inverted so a stale value never looks valid
  initial begin
    {req_valid, req, page_we, page_wdata, wreg_we, wreg_widx, wreg_wdata, wreg_ridx, prog_start} = '0;
  end
  task automatic set_page(input logic [7:0] p);
    @(negedge clk);
    {page_we, page_wdata} = {1'b1, p};
    @(negedge clk);
    {page_we, page_wdata} = {1'b0, ~p};
  endtask
  task automatic set_wreg(input logic [3:0] i, input logic [15:0] v);
    @(negedge clk);
    {wreg_we, wreg_widx, wreg_ridx, wreg_wdata} = {1'b1, i, i, v};
    @(negedge clk);
    {wreg_we, wreg_wdata} = {1'b0, ~v};
  endtask
  task automatic get_wreg(input logic [3:0] i, output logic [15:0] v);
    @(negedge clk);
    wreg_ridx = i;
    @(negedge clk);
    v = wreg_rdata;
  endtask
  task automatic do_op(input pft_op_e o, input logic bm, input logic pi, input logic [3:0] dw, output pft_resp_s r);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{o, bm, pi, 4'h1, dw};
    while (!req_ready) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req = pft_req_s'(~req);
    r = resp;
  endtask
  task automatic run_prog(output int n);
    @(negedge clk);
    prog_start = 1'b1;
    @(negedge clk);
    prog_start = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!prog_done && n < 300);
  endtask
endmodule
`default_nettype wire

// ===== verification/pft_table_access_tb.sv
// bench: writes two words into one row's latches, programs it, reads it back in every mode
// assumes the core model drives the block and the checker is bound below
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pft_table_access_tb
  import pft_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_ready, page_we, wreg_we, prog_start, prog_busy, prog_done;
  pft_req_s req;
  pft_resp_s resp;
  logic [7:0] page_wdata, table_page_reg;
  logic [3:0] wreg_widx, wreg_ridx;
  logic [15:0] wreg_wdata, wreg_rdata;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  pft_table_access #(.PM_WORDS(256)) i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp(resp), .page_we(page_we), .page_wdata(page_wdata),
    .table_page_reg(table_page_reg), .wreg_we(wreg_we), .wreg_widx(wreg_widx), .wreg_wdata(wreg_wdata),
    .wreg_ridx(wreg_ridx), .wreg_rdata(wreg_rdata), .prog_start(prog_start), .prog_busy(prog_busy),
    .prog_done(prog_done));
  pft_core_model i_core (.clk(clk), .req_ready(req_ready), .resp(resp), .wreg_rdata(wreg_rdata),
    .prog_done(prog_done), .req_valid(req_valid), .req(req), .page_we(page_we), .page_wdata(page_wdata),
    .wreg_we(wreg_we), .wreg_widx(wreg_widx), .wreg_wdata(wreg_wdata), .wreg_ridx(wreg_ridx),
    .prog_start(prog_start));
  // ==========================================================================
  // helpers and scenarios
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input pft_op_e o, input logic bm, input logic [15:0] ea, input logic [15:0] src);
    pft_resp_s r;
    i_core.set_wreg(4'h1, ea);
    i_core.set_wreg(4'h2, src);
    i_core.do_op(o, bm, 1'b0, 4'h2, r);
    `CHK("write done", 1'b1, r.done)
  endtask
  task automatic rd(input pft_op_e o, input logic bm, input logic pi, input logic [15:0] ea, exp, nea);
    pft_resp_s r;
    logic [15:0] w;
    i_core.set_wreg(4'h1, ea);
    i_core.do_op(o, bm, pi, 4'h3, r);
    i_core.get_wreg(4'h3, w);
    `CHK("read data", exp, r.rdata)
    `CHK("dest reg", exp, w)
    `CHK("next ea", nea, r.next_ea)
  endtask
  task automatic t_fill_program();
    int n;
    i_core.set_page(8'h5A);
    wr(PFT_TABLE_WRITE_LOW_OP, 1'b0, 16'h0010, 16'h1234);
    wr(PFT_TABLE_WRITE_HIGH_OP, 1'b0, 16'h0010, 16'hAB55);
    wr(PFT_TABLE_WRITE_HIGH_OP, 1'b1, 16'h0011, 16'h0077);
    wr(PFT_TABLE_WRITE_LOW_OP, 1'b1, 16'h0013, 16'hFF9C);
    i_core.run_prog(n);
    `CHK("row copy cycles", PFT_LATCH_COUNT, n)
  endtask
  task automatic t_read_words();
    rd(PFT_TABLE_READ_LOW_OP, 1'b0, 1'b0, 16'h0011, 16'h1234, 16'h0011);
    rd(PFT_TABLE_READ_HIGH_OP, 1'b0, 1'b0, 16'h0011, 16'h0055, 16'h0011);
    rd(PFT_TABLE_READ_LOW_OP, 1'b0, 1'b1, 16'h0010, 16'h1234, 16'h0012);
    `CHK("page kept", 8'h5A, table_page_reg)
  endtask
  task automatic t_read_bytes();
    rd(PFT_TABLE_READ_LOW_OP, 1'b1, 1'b1, 16'h0010, 16'h0034, 16'h0011);
    rd(PFT_TABLE_READ_LOW_OP, 1'b1, 1'b1, 16'h0011, 16'h0012, 16'h0012);
    rd(PFT_TABLE_READ_HIGH_OP, 1'b1, 1'b0, 16'h0010, 16'h0055, 16'h0010);
    rd(PFT_TABLE_READ_HIGH_OP, 1'b1, 1'b0, 16'h0011, 16'h0000, 16'h0011);
    rd(PFT_TABLE_READ_LOW_OP, 1'b1, 1'b0, 16'h0013, 16'h009C, 16'h0013);
  endtask
  // ==========================================================================
  // run and hang limit, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_fill_program();
    t_read_words();
    t_read_bytes();
    wrap_up();
  end
endmodule
bind pft_table_access pft_table_access_chk i_chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .resp(resp), .page_we(page_we), .page_wdata(page_wdata),
  .table_page_reg(table_page_reg), .wreg_we(wreg_we), .wreg_widx(wreg_widx), .wreg_wdata(wreg_wdata),
  .wreg_ridx(wreg_ridx), .wreg_rdata(wreg_rdata), .prog_start(prog_start), .prog_busy(prog_busy),
  .prog_done(prog_done));
`default_nettype wire
